// ---- design/registered_bus_transceiver.sv ----
// Registered eight-bit bus transceiver with an APB register block and a
// small log of captured words.
// Assumes all pins are asynchronous to clk_in and that the bench resolves
// the two bus wires from the output enables.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Small FIFO with valid and ready on both sides.
module log_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	// Storage and pointers; pointers carry one extra wrap bit.
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	// Full when the pointers differ only in the wrap bit.
	assign in_ready_out  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
	assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
	assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	// Write side.
	always_ff @(posedge clk_in)
	begin
		if (push)
		begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	// Pointer update.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
			rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
		end
	end
endmodule : log_fifo

////////////////////////////////////////////////////////////////////////////
// Top level: pins, channels, register block.
module registered_bus_transceiver #(
	parameter int DATA_W = transceiver_pkg::DATA_W
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic [DATA_W-1:0] port_a_bits_in,
	output logic [DATA_W-1:0]      port_a_bits_out,
	output logic [DATA_W-1:0]      port_a_bits_oe_out,
	input  wire logic [DATA_W-1:0] port_b_bits_in,
	output logic [DATA_W-1:0]      port_b_bits_out,
	output logic [DATA_W-1:0]      port_b_bits_oe_out,
	input  wire logic              a_to_b_output_enable_in,
	input  wire logic              b_to_a_output_enable_n_in,
	input  wire logic              a_side_capture_clock_in,
	input  wire logic              b_side_capture_clock_in,
	input  wire logic              a_to_b_source_select_in,
	input  wire logic              b_to_a_source_select_in,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr
);
	localparam int PW = transceiver_pkg::PIN_W;
	localparam int LW = 2 * DATA_W;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// Raw pins gathered in one vector.
	logic [PW-1:0] pin_vec;
	// First stage; only the second stage reads it.
	logic [PW-1:0] sync1_reg;
	// Second stage; all logic reads this one.
	logic [PW-1:0] sync2_reg;
	// Delayed capture clocks for edge detection.
	logic          cpa_d_reg;
	logic          cpb_d_reg;

	assign pin_vec = {b_side_capture_clock_in, a_side_capture_clock_in,
		b_to_a_source_select_in, a_to_b_source_select_in,
		b_to_a_output_enable_n_in, a_to_b_output_enable_in,
		port_b_bits_in, port_a_bits_in};

	// Two flip-flops on every pin before any logic looks at it.
	always_ff @(posedge clk_in)
	begin
		sync1_reg <= pin_vec;
		sync2_reg <= sync1_reg;
		cpa_d_reg <= sync2_reg[transceiver_pkg::PIN_CPA];
		cpb_d_reg <= sync2_reg[transceiver_pkg::PIN_CPB];
	end

	// Named views of the synchronised pins.
	logic [DATA_W-1:0] a_live;
	logic [DATA_W-1:0] b_live;
	logic              a_to_b_output_enable;
	logic              gba_n;
	logic              a_to_b_source_select;
	logic              b_to_a_source_select;
	logic              a_cap;
	logic              b_cap;

	assign a_live = sync2_reg[transceiver_pkg::PIN_A_LSB +: DATA_W];
	assign b_live = sync2_reg[transceiver_pkg::PIN_B_LSB +: DATA_W];
	assign a_to_b_output_enable    = sync2_reg[transceiver_pkg::PIN_GAB];
	assign gba_n  = sync2_reg[transceiver_pkg::PIN_GBA_N];
	assign a_to_b_source_select    = sync2_reg[transceiver_pkg::PIN_SAB];
	assign b_to_a_source_select    = sync2_reg[transceiver_pkg::PIN_SBA];
	// Rising edges of the capture clocks, whatever the enables say.
	assign a_cap  = sync2_reg[transceiver_pkg::PIN_CPA] & ~cpa_d_reg;
	assign b_cap  = sync2_reg[transceiver_pkg::PIN_CPB] & ~cpb_d_reg;

	////////////////////////////////////////////////////////////////////////
	// Register block state.

	// Control register; its enable bit gates both drivers.
	logic [31:0] ctrl_reg;
	// Sticky flag: a capture found the log full.
	logic        ovf_reg;
	logic        drive_en;
	logic        b_drive;
	logic        a_drive;

	assign drive_en = ctrl_reg[transceiver_pkg::CTRL_EN_BIT];
	// Port B driven on high enable, port A on low enable.
	assign b_drive  = drive_en & a_to_b_output_enable;
	assign a_drive  = drive_en & ~gba_n;

	////////////////////////////////////////////////////////////////////////
	// Eight identical channels.

	// Stored words gathered from the channels.
	logic [DATA_W-1:0] a_stored;
	logic [DATA_W-1:0] b_stored;

	generate
		for (genvar i = 0; i < DATA_W; i++)
		begin : g_chan
			// One storage flip-flop per direction, no reset.
			logic a_bit_reg;
			logic b_bit_reg;
			// Registered pin drive for this bit.
			logic a_out_reg;
			logic b_out_reg;
			logic a_oe_reg;
			logic b_oe_reg;

			// Load each register from its own port on its clock edge.
			// The B side samples the B wire, so when B is driven from A
			// both registers end up with the A-derived word, and vice
			// versa.
			always_ff @(posedge clk_in)
			begin
				if (a_cap)
				begin
					a_bit_reg <= a_live[i];
				end
				if (b_cap)
				begin
					b_bit_reg <= b_live[i];
				end
			end

			// Output stage. Choosing the source inside a flip-flop means
			// the pin only changes on a clock edge, so a select switch
			// with equal live and stored data cannot glitch. Live data
			// skips the storage flip-flop but passes both synchroniser stages and this pin register.
			always_ff @(posedge clk_in)
			begin
				if (rst_in)
				begin
					a_out_reg <= 1'b0;
					b_out_reg <= 1'b0;
					a_oe_reg  <= 1'b0;
					b_oe_reg  <= 1'b0;
				end
				else
				begin
					b_out_reg <= a_to_b_source_select ? a_bit_reg : a_live[i];
					a_out_reg <= b_to_a_source_select ? b_bit_reg : b_live[i];
					b_oe_reg  <= b_drive;
					a_oe_reg  <= a_drive;
				end
			end

			assign a_stored[i]           = a_bit_reg;
			assign b_stored[i]           = b_bit_reg;
			assign port_a_bits_out[i]    = a_out_reg;
			assign port_b_bits_out[i]    = b_out_reg;
			assign port_a_bits_oe_out[i] = a_oe_reg;
			assign port_b_bits_oe_out[i] = b_oe_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Capture log: every capture that finds room pushes both stored words as they will be.

	logic          log_push;
	logic [LW-1:0] log_word;
	logic          log_ready;
	logic          log_valid;
	logic [LW-1:0] log_head;
	logic          log_pop;

	assign log_push = a_cap | b_cap;
	assign log_word = {b_cap ? b_live : b_stored, a_cap ? a_live : a_stored};

	log_fifo #(
		.WIDTH (LW),
		.DEPTH (transceiver_pkg::LOG_DEPTH)
	) u_log (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (log_push),
		.in_data_in    (log_word),
		.in_ready_out  (log_ready),
		.out_valid_out (log_valid),
		.out_data_out  (log_head),
		.out_ready_in  (log_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// APB slave: pready rises one cycle into the access phase.

	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;
	logic        access;
	logic        pready_next;
	logic        done;
	logic        sel_ctrl;
	logic        sel_stat;
	logic        sel_log;
	logic        sel_clr;
	logic        hit;
	logic        clr_ovf;
	logic [31:0] status_word;
	logic [31:0] log_read;
	logic [31:0] rd_mux;

	assign access      = psel & penable;
	assign pready_next = access & ~pready_reg;
	assign done        = access & pready_reg;
	assign sel_ctrl    = paddr == transceiver_pkg::CTRL_ADDR;
	assign sel_stat    = paddr == transceiver_pkg::STATUS_ADDR;
	assign sel_log     = paddr == transceiver_pkg::LOG_ADDR;
	assign sel_clr     = paddr == transceiver_pkg::CLEAR_ADDR;
	assign hit         = sel_ctrl | sel_stat | sel_log | sel_clr;
	assign log_pop     = done & ~pwrite & sel_log;
	assign clr_ovf     = done & pwrite & sel_clr
		& pwdata[transceiver_pkg::CLR_OVF_BIT];

	// Status shows both stored words and the log state.
	assign status_word = {13'h0, ovf_reg, ~log_ready, log_valid,
		b_stored, a_stored};
	assign log_read    = {15'h0, log_valid, log_head};

	// Read selection; unmapped reads return zero.
	assign rd_mux = sel_ctrl ? ctrl_reg
		: sel_stat ? status_word
		: sel_log ? log_read
		: 32'h00000000;

	// Handshake, read data and error flag.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= pready_next;
			pslverr_reg <= pready_next & ~hit;
			prdata_reg  <= (pready_next & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Control writes, and the overflow flag where a set beats a clear.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ctrl_reg <= transceiver_pkg::CTRL_RESET;
			ovf_reg  <= 1'b0;
		end
		else
		begin
			if (done & pwrite & sel_ctrl)
			begin
				ctrl_reg <= pwdata & transceiver_pkg::CTRL_RESET;
			end
			ovf_reg <= (log_push & ~log_ready) | (ovf_reg & ~clr_ovf);
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_a_edge;
		a_cap;
	endsequence

	sequence s_b_edge;
		b_cap;
	endsequence

	property p_a_capture;
		s_a_edge |=> a_stored == $past(a_live);
	endproperty
	a_a_capture : assert property (p_a_capture)
		else $error("A-side register missed its capture.");

	property p_b_capture;
		s_b_edge |=> b_stored == $past(b_live);
	endproperty
	a_b_capture : assert property (p_b_capture)
		else $error("B-side register missed its capture.");

	property p_isolate;
		!a_to_b_output_enable && gba_n |=> port_a_bits_oe_out == '0
			&& port_b_bits_oe_out == '0;
	endproperty
	a_isolate : assert property (p_isolate)
		else $error("A port is driven while isolated.");

	property p_a_live;
		a_drive && !b_to_a_source_select |=> port_a_bits_oe_out == '1
			&& port_a_bits_out == $past(b_live);
	endproperty
	a_a_live : assert property (p_a_live)
		else $error("Port A does not carry live B data.");

	property p_a_stored;
		a_drive && b_to_a_source_select |=> port_a_bits_out == $past(b_stored);
	endproperty
	a_a_stored : assert property (p_a_stored)
		else $error("Port A does not carry the stored B word.");

	property p_b_live;
		b_drive && !a_to_b_source_select |=> port_b_bits_oe_out == '1
			&& port_b_bits_out == $past(a_live);
	endproperty
	a_b_live : assert property (p_b_live)
		else $error("Port B does not carry live A data.");

	property p_both_stored;
		a_drive && b_drive && a_to_b_source_select && b_to_a_source_select
			|=> port_b_bits_out == $past(a_stored)
			&& port_a_bits_out == $past(b_stored);
	endproperty
	a_both_stored : assert property (p_both_stored)
		else $error("Stored words not driven on both ports.");

	property p_no_glitch;
		b_drive && a_live == a_stored [*2]
			|=> $stable(port_b_bits_out);
	endproperty
	a_no_glitch : assert property (p_no_glitch)
		else $error("Port B moved although sources agree.");

	property p_reinforce;
		a_drive && b_drive && !a_to_b_source_select && !b_to_a_source_select
			|=> port_a_bits_out == $past(b_live)
			&& port_b_bits_out == $past(a_live);
	endproperty
	a_reinforce : assert property (p_reinforce)
		else $error("Live loop does not hold the buses.");

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse : assert property (p_ready_pulse)
		else $error("Ready stayed high for two cycles.");

endmodule : registered_bus_transceiver

`default_nettype wire

// ---- design/transceiver_pkg.sv ----
// Constants for the registered bus transceiver: register map, fields,
// reset values and pin vector layout.
// Assumes an APB master with 32-bit data and byte addresses.
package transceiver_pkg;

	// Data width of one port.
	localparam int DATA_W = 8;
	// Depth of the capture log FIFO.
	localparam int LOG_DEPTH = 4;

	// Register byte addresses.
	localparam logic [31:0] CTRL_ADDR   = 32'h00000000;
	localparam logic [31:0] STATUS_ADDR = 32'h00000004;
	localparam logic [31:0] LOG_ADDR    = 32'h00000008;
	localparam logic [31:0] CLEAR_ADDR  = 32'h0000000C;

	// Control register fields and reset value.
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET  = 32'h00000001;

	// Status register fields.
	localparam int STAT_A_LSB    = 0;
	localparam int STAT_B_LSB    = 8;
	localparam int STAT_NEMPTY   = 16;
	localparam int STAT_FULL     = 17;
	localparam int STAT_OVF      = 18;

	// Log register valid flag and clear register bit.
	localparam int LOG_VALID_BIT = 16;
	localparam int CLR_OVF_BIT   = 0;

	// Layout of the synchronised pin vector.
	localparam int PIN_A_LSB = 0;
	localparam int PIN_B_LSB = 8;
	localparam int PIN_GAB   = 16;
	localparam int PIN_GBA_N = 17;
	localparam int PIN_SAB   = 18;
	localparam int PIN_SBA   = 19;
	localparam int PIN_CPA   = 20;
	localparam int PIN_CPB   = 21;
	localparam int PIN_W     = 22;

endpackage : transceiver_pkg

// ---- verification/bus_partner.sv ----
// Far-side logic model on bus A and bus B.
// Assumes the bench sets the drive values just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Resolves both wires from the far side and the device enables.
module bus_partner (
	input  wire logic       clk_in,
	input  wire logic       a_drv_in,
	input  wire logic [7:0] a_val_in,
	input  wire logic       b_drv_in,
	input  wire logic [7:0] b_val_in,
	input  wire logic [7:0] a_dev_in,
	input  wire logic [7:0] a_dev_oe_in,
	input  wire logic [7:0] b_dev_in,
	input  wire logic [7:0] b_dev_oe_in,
	output logic      [7:0] a_wire_out,
	output logic      [7:0] b_wire_out
);
	// Last wire levels; a floating bit shows their inverse.
	logic [7:0] a_last;
	logic [7:0] b_last;

	// Far-side drive wins, then device bits, else the floating pattern.
	assign a_wire_out = a_drv_in ? a_val_in
		: (a_dev_in & a_dev_oe_in) | (~a_last & ~a_dev_oe_in);
	assign b_wire_out = b_drv_in ? b_val_in
		: (b_dev_in & b_dev_oe_in) | (~b_last & ~b_dev_oe_in);

	// Remembers the levels so an undriven bus changes every cycle.
	always_ff @(posedge clk_in)
	begin
		a_last <= a_wire_out;
		b_last <= b_wire_out;
	end
endmodule : bus_partner

`default_nettype wire

// ---- verification/tb_registered_bus_transceiver.sv ----
// Self-checking bench for the registered bus transceiver.
// Assumes the far-side model resolves both bus wires.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Bench top.
module tb_registered_bus_transceiver;
	logic        clk_in, rst_in, ab_en, ba_en_n, cap_a, cap_b, ab_sel, ba_sel;
	logic        psel, penable, pwrite, pready, pslverr, a_drv, b_drv;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [7:0]  a_val, b_val, a_wire, b_wire, a_out, a_oe, b_out, b_oe;
	logic        er;
	int          fail_count, checks_done;

	// Device under test.
	registered_bus_transceiver u_registered_bus_transceiver (
		.clk_in(clk_in), .rst_in(rst_in),
		.port_a_bits_in(a_wire), .port_a_bits_out(a_out),
		.port_a_bits_oe_out(a_oe), .port_b_bits_in(b_wire),
		.port_b_bits_out(b_out), .port_b_bits_oe_out(b_oe),
		.a_to_b_output_enable_in(ab_en), .b_to_a_output_enable_n_in(ba_en_n),
		.a_side_capture_clock_in(cap_a), .b_side_capture_clock_in(cap_b),
		.a_to_b_source_select_in(ab_sel), .b_to_a_source_select_in(ba_sel),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Far-side logic on both buses.
	bus_partner u_bus_partner (
		.clk_in(clk_in), .a_drv_in(a_drv), .a_val_in(a_val),
		.b_drv_in(b_drv), .b_val_in(b_val), .a_dev_in(a_out),
		.a_dev_oe_in(a_oe), .b_dev_in(b_out), .b_dev_oe_in(b_oe),
		.a_wire_out(a_wire), .b_wire_out(b_wire));

	// Clock of 4 ns.
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tick

	// Compares one 32-bit result and counts it.
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One APB transfer; an idle cycle follows so transfers never collide.
	// The wait for ready is open ended; only the watchdog cuts it short.
	// The slave inserts one wait state, so ready is seen at the second
	// edge of the access phase.
	task automatic apb(input logic wr, input logic [31:0] ad,
		input logic [31:0] wd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready !== 1'b1);
		check("pready wait", 32'h00000002, 32'(n));
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_in);
	endtask : apb

	// Capture pulse, high and low three cycles each.
	task automatic pulse(input logic a, input logic b);
		cap_a <= a;
		cap_b <= b;
		tick(3);
		cap_a <= 1'b0;
		cap_b <= 1'b0;
		tick(3);
	endtask : pulse

	// Reset state, control bits and an unmapped place.
	task automatic t_regs();
		apb(1'b0, transceiver_pkg::CTRL_ADDR, 32'h0);
		check("ctrl reset", transceiver_pkg::CTRL_RESET, rd);
		check("isolated oe", 32'h0, {16'h0, a_oe, b_oe});
		apb(1'b1, transceiver_pkg::CTRL_ADDR, 32'hFFFFFFFF);
		apb(1'b0, transceiver_pkg::CTRL_ADDR, 32'h0);
		check("ctrl bits", 32'h00000001, rd);
		apb(1'b0, 32'h00000010, 32'h0);
		check("unmapped", 32'h00000001, {rd[30:0], er});
	endtask : t_regs

	// Live A onto B, its latency, and drive disable.
	task automatic t_live_ab();
		{a_drv, a_val, b_drv} <= {1'b1, 8'h5A, 1'b0};
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b1100;
		tick(6);
		check("b live", 32'h0000FF5A, {16'h0, b_oe, b_out});
		check("a off", 32'h0, {24'h0, a_oe});
		a_val <= 8'hA5;
		tick(5);
		check("b latency", 32'h000000A5, {24'h0, b_out});
		apb(1'b1, transceiver_pkg::CTRL_ADDR, 32'h0);
		tick(4);
		check("ctrl off", 32'h0, {24'h0, b_oe});
		apb(1'b1, transceiver_pkg::CTRL_ADDR, 32'h1);
	endtask : t_live_ab

	// Live B onto A.
	task automatic t_live_ba();
		{a_drv, b_drv, b_val} <= {1'b0, 1'b1, 8'hC3};
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b0000;
		tick(6);
		check("a live", 32'h0000FFC3, {16'h0, a_oe, a_out});
		check("b off", 32'h0, {24'h0, b_oe});
	endtask : t_live_ba

	// Isolated capture, then both ports driven from stored words.
	task automatic t_capture();
		{a_drv, a_val, b_drv, b_val} <= {1'b1, 8'hF0, 1'b1, 8'h0F};
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b0100;
		tick(5);
		pulse(1'b1, 1'b1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("stored", 32'h00000FF0, rd & 32'h0000FFFF);
		{a_drv, b_drv} <= 2'b00;
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b1011;
		tick(6);
		check("both stored", 32'hFF0FFFF0, {a_oe, a_out, b_oe, b_out});
	endtask : t_capture

	// A drives B; both load A, source switch, staggered load.
	task automatic t_both_a();
		{a_drv, a_val} <= {1'b1, 8'h77};
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b1100;
		tick(6);
		pulse(1'b1, 1'b1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("both from a", 32'h00007777, rd & 32'h0000FFFF);
		for (int i = 0; i < 8; i++)
		begin
			ab_sel <= i[1];
			tick(1);
			check("no glitch", 32'h00000077, {24'h0, b_out});
		end
		a_val <= 8'h3C;
		tick(5);
		check("b stored", 32'h00000077, {24'h0, b_out});
		pulse(1'b1, 1'b0);
		tick(3);
		pulse(1'b0, 1'b1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("staggered", 32'h00003C3C, rd & 32'h0000FFFF);
	endtask : t_both_a

	// B drives A; both load B; then both live paths hold the buses.
	task automatic t_both_b();
		{a_drv, b_drv, b_val} <= {1'b0, 1'b1, 8'h99};
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b0000;
		tick(6);
		pulse(1'b1, 1'b1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("both from b", 32'h00009999, rd & 32'h0000FFFF);
		{ab_en, ab_sel} <= 2'b10;
		tick(6);
		b_drv <= 1'b0;
		tick(20);
		check("held", 32'h00009999, {16'h0, a_wire, b_wire});
	endtask : t_both_b

	// Mid-run reset, log filled past full, drained, overflow cleared.
	task automatic t_log();
		rst_in <= 1'b1;
		tick(5);
		rst_in <= 1'b0;
		tick(1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("kept words", 32'h00009999, rd);
		{a_drv, b_drv} <= 2'b10;
		{ab_en, ba_en_n, ab_sel, ba_sel} <= 4'b0100;
		for (int i = 0; i < 5; i++)
		begin
			a_val <= 8'hA0 + 8'(i);
			tick(3);
			pulse(1'b1, 1'b0);
		end
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("log full", 32'h000799A4, rd);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, transceiver_pkg::LOG_ADDR, 32'h0);
			check("log entry", 32'h000199A0 + 32'(i), rd);
		end
		apb(1'b0, transceiver_pkg::LOG_ADDR, 32'h0);
		check("log empty", 32'h0, rd & 32'h00010000);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("drained", 32'h000499A4, rd);
		apb(1'b1, transceiver_pkg::CLEAR_ADDR, 32'h1);
		apb(1'b0, transceiver_pkg::STATUS_ADDR, 32'h0);
		check("cleared", 32'h000099A4, rd);
	endtask : t_log

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	// Cuts a hang short after 5000 cycles.
	initial
	begin
		#20000;
		fail_count++;
		give_verdict();
	end

	// Main sequence.
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		rst_in = 1'b1;
		{ab_en, ba_en_n, cap_a, cap_b, ab_sel, ba_sel} = 6'b010000;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{a_drv, a_val, b_drv, b_val} = {1'b1, 8'h00, 1'b1, 8'h00};
		tick(5);
		rst_in <= 1'b0;
		tick(1);
		t_regs();
		t_live_ab();
		t_live_ba();
		t_capture();
		t_both_a();
		t_both_b();
		t_log();
		give_verdict();
	end
endmodule : tb_registered_bus_transceiver

`default_nettype wire
